// File: dv/keyed_pll_power_control_checker.sv
// Port assertions for the keyed PLL and power control block.
`include "keyed_pll_map.vh"
`timescale 1ns/100ps
module keyed_pll_power_control_checker (
  input wire        clk_in,
  input wire        nrst_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire        pwrite_in,
  input wire [31:0] paddr_in,
  input wire [31:0] pwdata_in,
  input wire        pready_out,
  input wire        pll_locked_in,
  input wire        wake_event_in,
  input wire        pll_source_precision_out,
  input wire        pll_run_out,
  input wire [2:0]  core_clock_divider_out,
  input wire        core_locked_out,
  input wire        pll_int_flag_out
);
  // ----------------------------------------
  // Cycles since the last postwrite key write
  // ----------------------------------------
  wire      acc = psel_in && penable_in && pready_out && pwrite_in;
  wire      clr = acc && paddr_in == `ADDR_PLL_LOCK_STATUS && pwdata_in[0];
  reg [1:0] since_key;
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      since_key <= 2'h3;
    end else if (acc && (paddr_in == `ADDR_POWER_POSTWRITE_KEY ||
                         paddr_in == `ADDR_PLL_POSTWRITE_KEY)) begin
      since_key <= 2'h0;
    end else if (since_key != 2'h3) begin
      since_key <= since_key + 2'h1;
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  a_ready_zero_wait: assert property (psel_in && penable_in |-> pready_out)
    else $error("no ready in access phase");
  a_ready_one_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready held too long");
  a_lock_rise: assert property ($rose(pll_locked_in) |-> ##[1:3] core_locked_out)
    else $error("lock not reported");
  a_lock_fall: assert property ($fell(pll_locked_in) |-> ##[1:3] !core_locked_out)
    else $error("lock loss not reported");
  a_flag_on_loss: assert property ($fell(core_locked_out) |-> ##[0:2] pll_int_flag_out)
    else $error("flag not set on lock loss");
  a_flag_sticky: assert property (pll_int_flag_out && !clr && !$past(clr)
    |=> pll_int_flag_out)
    else $error("flag dropped by itself");
  a_flag_clear: assert property (clr && core_locked_out && pll_locked_in
    |-> ##2 !pll_int_flag_out)
    else $error("flag not cleared");
  a_divider_keyed: assert property ($changed(core_clock_divider_out)
    |-> since_key != 2'h3)
    else $error("divider changed without key");
  a_source_keyed: assert property ($changed(pll_source_precision_out)
    |-> since_key != 2'h3)
    else $error("source changed without key");
  a_wake_runs: assert property ($rose(wake_event_in) |-> ##[1:4] pll_run_out)
    else $error("wake did not run pll");
endmodule

// File: dv/keyed_pll_power_control_test.sv
// Self-checking bench for the keyed PLL and power control block.
`include "keyed_pll_map.vh"
`timescale 1ns/100ps
module keyed_pll_power_control_test;
  logic        clk_in = 1'h0;
  logic        nrst_in = 1'h0;
  logic        psel_in = 1'h0;
  logic        penable_in = 1'h0;
  logic        pwrite_in = 1'h0;
  logic [31:0] paddr_in = 32'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic        pll_locked_in = 1'h0;
  logic        wake_event_in = 1'h0;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, pll_source_precision_out;
  wire         pll_run_out, precision_osc_en_out, core_locked_out;
  wire         core_tick_out, pll_int_flag_out;
  wire  [2:0]  core_clock_divider_out;
  logic        err_seen;
  int          error_cnt = 0;
  int          compares = 0;
  localparam logic [31:0] pm = `ADDR_POWER_MODE_CONTROL;
  localparam logic [31:0] st = `ADDR_PLL_LOCK_STATUS;
  keyed_pll_power_control dut_u (.*);
  always #2.5 clk_in = ~clk_in;
  // ----------------------------------------
  // Bus and comparison tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, d, m);
    int n;
    n = 0;
    @(posedge clk_in);
    psel_in <= 1'h1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
    end while (pready_out !== 1'h1 && n < 20);
    err_seen = pslverr_out;
    if (n >= 20) error_cnt++;
    if (!w) chk(prdata_out & m, d & m);
    psel_in <= 1'h0;
    penable_in <= 1'h0;
  endtask
  task automatic keyed(input logic [31:0] pa, pk, ra, d, qa, qk);
    apb(1'h1, pa, pk, 32'h0);
    apb(1'h1, ra, d, 32'h0);
    apb(1'h1, qa, qk, 32'h0);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic pow(input logic [31:0] pk, d, qk);
    keyed(`ADDR_POWER_PREWRITE_KEY, pk, pm, d, `ADDR_POWER_POSTWRITE_KEY, qk);
  endtask
  task automatic src(input logic [31:0] pk, d, qk);
    keyed(`ADDR_PLL_PREWRITE_KEY, pk, `ADDR_PLL_SOURCE_SELECT, d,
          `ADDR_PLL_POSTWRITE_KEY, qk);
  endtask
  task automatic ticks(input logic [31:0] exp);
    logic [31:0] c;
    c = 32'h0;
    repeat (64) begin
      @(posedge clk_in);
      if (core_tick_out === 1'h1) c++;
    end
    chk(c, exp);
  endtask
  task automatic conclude();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ----------------------------------------
  // Test sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (20) @(posedge clk_in);
    nrst_in <= 1'h1;
    apb(1'h0, pm, 32'h079, 32'hfff);
    apb(1'h0, `ADDR_PLL_SOURCE_SELECT, 32'h0, 32'hff);
    chk({pll_run_out, precision_osc_en_out, core_clock_divider_out}, 32'h11);
    apb(1'h1, pm, 32'h0, 32'h0);
    apb(1'h0, pm, 32'h079, 32'hfff);
    pow(`KEY_POWER_PRE, 32'h107, `KEY_POWER_POST);
    apb(1'h0, pm, 32'h107, 32'hfff);
    chk({pll_run_out, precision_osc_en_out, core_clock_divider_out}, 32'h0f);
    pow(`KEY_POWER_PRE, 32'h0, 32'hf5);
    apb(1'h0, pm, 32'h107, 32'hfff);
    src(32'hab, 32'h1, `KEY_PLL_POST);
    apb(1'h0, `ADDR_PLL_SOURCE_SELECT, 32'h0, 32'hff);
    src(`KEY_PLL_PRE, 32'h1, `KEY_PLL_POST);
    apb(1'h0, `ADDR_PLL_SOURCE_SELECT, 32'h1, 32'hff);
    chk(pll_source_precision_out, 32'h1);
    apb(1'h0, st, 32'h0, 32'hff);
    ticks(32'h8);
    pll_locked_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    apb(1'h0, st, 32'h2, 32'hff);
    pow(`KEY_POWER_PRE, 32'h102, `KEY_POWER_POST);
    ticks(32'h10);
    pll_locked_in <= 1'h0;
    repeat (6) @(posedge clk_in);
    apb(1'h0, st, 32'h1, 32'hff);
    ticks(32'h8);
    pll_locked_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    apb(1'h1, st, 32'h0, 32'h0);
    apb(1'h0, st, 32'h3, 32'hff);
    apb(1'h1, st, 32'h1, 32'h0);
    apb(1'h0, st, 32'h2, 32'hff);
    wake_event_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    chk(pll_run_out, 32'h1);
    apb(1'h0, pm, 32'h020, 32'h020);
    wake_event_in <= 1'h0;
    apb(1'h0, 32'hffff041c, 32'h0, 32'hffffffff);
    chk(err_seen, 32'h1);
    conclude();
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    error_cnt++;
    conclude();
  end
endmodule
bind keyed_pll_power_control keyed_pll_power_control_checker chk_u (.*);

// File: logic/core_clock_divider.v
// Core clock enable generator: divides by 2**code, or by eight while unlocked.
`include "keyed_pll_map.vh"
`timescale 1ns/100ps
module core_clock_divider (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire [2:0] core_clock_divider_in,
  input  wire       locked_in,
  output reg        core_tick_out
);

  reg  [6:0] count_reg;
  wire [6:0] limit;

  // While unlocked the core runs from the slow fallback divide.
  assign limit = locked_in ? ((7'h01 << core_clock_divider_in) - 7'h01)
                           : (`PLL_SLOW_DIVIDE - 7'h01);

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count_reg     <= 7'h00;
      core_tick_out <= 1'b0;
    end else if (count_reg >= limit) begin
      count_reg     <= 7'h00;
      core_tick_out <= 1'b1;
    end else begin
      count_reg     <= count_reg + 7'h01;
      core_tick_out <= 1'b0;
    end
  end

endmodule

// File: logic/keyed_pll_map.vh
// Register map, field positions, reset values and timing for PLL/power control.
`ifndef KEYED_PLL_MAP_VH
`define KEYED_PLL_MAP_VH

`define ADDR_PLL_LOCK_STATUS       32'hffff0400
`define ADDR_POWER_PREWRITE_KEY    32'hffff0404
`define ADDR_POWER_MODE_CONTROL    32'hffff0408
`define ADDR_POWER_POSTWRITE_KEY   32'hffff040c
`define ADDR_PLL_PREWRITE_KEY      32'hffff0410
`define ADDR_PLL_SOURCE_SELECT     32'hffff0414
`define ADDR_PLL_POSTWRITE_KEY     32'hffff0418

`define KEY_PLL_PRE                32'h000000aa
`define KEY_PLL_POST               32'h00000055
`define KEY_POWER_PRE              32'h00000001
`define KEY_POWER_POST             32'h000000f4

`define BIT_PLL_INT_FLAG           0
`define BIT_PLL_LOCKED             1
`define BIT_PLL_SOURCE             0
`define BIT_PLL_RUN                5
`define BIT_PRECISION_OSC_EN       8
`define POWER_MODE_WRITABLE        12'h038
`define POWER_MODE_DIVIDER_MSB     2

`define RESET_PLL_SOURCE_SELECT    8'h00
`define RESET_POWER_MODE_CONTROL   12'h079

`define PLL_SLOW_DIVIDE            7'd8
`define PLL_SLOW_DIVIDE_WIDTH      3

`endif

// File: logic/keyed_pll_power_control.v
// PLL lock status, keyed PLL source select and keyed power-mode control.
//
// Summary of operation
// - Lock bit high while PLL locked.
// - Lock bit low when unlocked; divide-by-8 core.
// - Lock falling edge sets sticky interrupt flag.
// - Writing one clears the flag; zero ignored.
// - Status is 8 bits, upper six reserved.
// - PLL prewrite key precedes source write.
// - PLL postwrite key follows source write.
// - Source bit 0 picks precision oscillator.
// - Source register 8 bits, resets to zero.
// - Power prewrite key precedes control write.
// - Power postwrite key follows control write.
// - Power control 12 bits, resets 0x079.
// - Bits 2-0 select core clock divider.
// - Bit 5 runs PLL; wake-up sets it, but a wake edge that meets an APB write access in the same cycle is dropped.
// - Bit 8 enables precision oscillator.
//
// Implementation choice: the APB register port.
`include "keyed_pll_map.vh"
`timescale 1ns/100ps
module keyed_pll_power_control (
  input  wire        clk_in,
  input  wire        nrst_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [31:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out,
  input  wire        pll_locked_in,
  input  wire        wake_event_in,
  output reg         pll_source_precision_out,
  output reg         pll_run_out,
  output reg         precision_osc_en_out,
  output reg  [2:0]  core_clock_divider_out,
  output reg         core_locked_out,
  output wire        core_tick_out,
  output reg         pll_int_flag_out
);

  // ---------------------------------------------------------------
  // Key sequencer states
  // ---------------------------------------------------------------
  localparam ST_IDLE      = 2'b00;
  localparam ST_PRE_OK    = 2'b01;
  localparam ST_HELD      = 2'b10;

  reg  [1:0]  pll_state_reg;
  reg  [1:0]  pow_state_reg;
  reg  [7:0]  pll_source_reg;
  reg  [7:0]  pll_pending_reg;
  reg  [11:0] power_mode_reg;
  reg  [11:0] power_pending_reg;
  reg         int_flag_reg;
  reg         lock_prev_reg;
  reg         wake_prev_reg;
  wire        lock_sync;
  wire        wake_sync;
  wire        wr_access;
  wire        rd_access;
  wire        addr_known;

  // ---------------------------------------------------------------
  // Input synchronisers and core clock divider
  // ---------------------------------------------------------------
  sync_two_flop lock_sync_u (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (pll_locked_in),
    .q_out   (lock_sync)
  );

  sync_two_flop wake_sync_u (
    .clk_in  (clk_in),
    .nrst_in (nrst_in),
    .d_in    (wake_event_in),
    .q_out   (wake_sync)
  );

  core_clock_divider divider_u (
    .clk_in                (clk_in),
    .nrst_in               (nrst_in),
    .core_clock_divider_in (power_mode_reg[`POWER_MODE_DIVIDER_MSB:0]),
    .locked_in             (lock_sync),
    .core_tick_out         (core_tick_out)
  );

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  function is_addr;
    input [31:0] a;
    input [31:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  assign wr_access = psel_in & penable_in & pwrite_in;
  assign rd_access = psel_in & ~penable_in & ~pwrite_in;
  assign addr_known = is_addr(paddr_in, `ADDR_PLL_LOCK_STATUS) |
                      is_addr(paddr_in, `ADDR_POWER_PREWRITE_KEY) |
                      is_addr(paddr_in, `ADDR_POWER_MODE_CONTROL) |
                      is_addr(paddr_in, `ADDR_POWER_POSTWRITE_KEY) |
                      is_addr(paddr_in, `ADDR_PLL_PREWRITE_KEY) |
                      is_addr(paddr_in, `ADDR_PLL_SOURCE_SELECT) |
                      is_addr(paddr_in, `ADDR_PLL_POSTWRITE_KEY);

  // Zero-wait slave: ready and error are valid in every access phase.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pready_out  <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out  <= 32'h00000000;
    end else begin
      pready_out  <= psel_in & ~penable_in;
      pslverr_out <= psel_in & ~penable_in & ~addr_known;
      if (rd_access) begin
        if (is_addr(paddr_in, `ADDR_PLL_LOCK_STATUS))
          prdata_out <= {30'h00000000, lock_sync, int_flag_reg};
        else if (is_addr(paddr_in, `ADDR_POWER_MODE_CONTROL))
          prdata_out <= {20'h00000, power_mode_reg};
        else if (is_addr(paddr_in, `ADDR_PLL_SOURCE_SELECT))
          prdata_out <= {24'h000000, pll_source_reg};
        else
          prdata_out <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Lock status and sticky interrupt flag
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      lock_prev_reg <= 1'b0;
      int_flag_reg  <= 1'b0;
    end else begin
      lock_prev_reg <= lock_sync;
      // A falling edge of lock outranks a same-cycle clear.
      if (lock_prev_reg & ~lock_sync)
        int_flag_reg <= 1'b1;
      else if (wr_access & pready_out &
               is_addr(paddr_in, `ADDR_PLL_LOCK_STATUS) &
               pwdata_in[`BIT_PLL_INT_FLAG])
        int_flag_reg <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Keyed PLL source select
  // ---------------------------------------------------------------
  // Any other write between the keys aborts the sequence.
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_state_reg   <= ST_IDLE;
      pll_source_reg  <= `RESET_PLL_SOURCE_SELECT;
      pll_pending_reg <= 8'h00;
    end else if (wr_access & pready_out) begin
      case (pll_state_reg)
        ST_IDLE: begin
          if (is_addr(paddr_in, `ADDR_PLL_PREWRITE_KEY) &
              pwdata_in == `KEY_PLL_PRE)
            pll_state_reg <= ST_PRE_OK;
        end
        ST_PRE_OK: begin
          if (is_addr(paddr_in, `ADDR_PLL_SOURCE_SELECT)) begin
            pll_pending_reg <= pwdata_in[7:0];
            pll_state_reg   <= ST_HELD;
          end else begin
            pll_state_reg <= ST_IDLE;
          end
        end
        ST_HELD: begin
          if (is_addr(paddr_in, `ADDR_PLL_POSTWRITE_KEY) &
              pwdata_in == `KEY_PLL_POST)
            pll_source_reg <= pll_pending_reg;
          pll_state_reg <= ST_IDLE;
        end
        default: begin
          pll_state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Keyed power-mode control
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pow_state_reg     <= ST_IDLE;
      power_mode_reg    <= `RESET_POWER_MODE_CONTROL;
      power_pending_reg <= 12'h000;
      wake_prev_reg     <= 1'b0;
    end else begin
      wake_prev_reg <= wake_sync;
      if (wr_access & pready_out) begin
        case (pow_state_reg)
          ST_IDLE: begin
            if (is_addr(paddr_in, `ADDR_POWER_PREWRITE_KEY) &
                pwdata_in == `KEY_POWER_PRE)
              pow_state_reg <= ST_PRE_OK;
          end
          ST_PRE_OK: begin
            if (is_addr(paddr_in, `ADDR_POWER_MODE_CONTROL)) begin
              power_pending_reg <= pwdata_in[11:0];
              pow_state_reg     <= ST_HELD;
            end else begin
              pow_state_reg <= ST_IDLE;
            end
          end
          ST_HELD: begin
            if (is_addr(paddr_in, `ADDR_POWER_POSTWRITE_KEY) &
                pwdata_in == `KEY_POWER_POST)
              power_mode_reg <= power_pending_reg;
            pow_state_reg <= ST_IDLE;
          end
          default: begin
            pow_state_reg <= ST_IDLE;
          end
        endcase
      end else if (wake_sync & ~wake_prev_reg) begin
        // Wake-up restores the PLL, peripheral and core run bits.
        power_mode_reg <= power_mode_reg | `POWER_MODE_WRITABLE;
      end
    end
  end

  // ---------------------------------------------------------------
  // Registered control outputs
  // ---------------------------------------------------------------
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pll_source_precision_out <= 1'b0;
      pll_run_out              <= 1'b1;
      precision_osc_en_out     <= 1'b0;
      core_clock_divider_out   <= 3'h1;
      core_locked_out          <= 1'b0;
      pll_int_flag_out         <= 1'b0;
    end else begin
      pll_source_precision_out <= pll_source_reg[`BIT_PLL_SOURCE];
      pll_run_out              <= power_mode_reg[`BIT_PLL_RUN];
      precision_osc_en_out     <= power_mode_reg[`BIT_PRECISION_OSC_EN];
      core_clock_divider_out   <= power_mode_reg[2:0];
      core_locked_out          <= lock_sync;
      pll_int_flag_out         <= int_flag_reg;
    end
  end

endmodule

// File: logic/sync_two_flop.v
// Two flip-flop synchroniser for a single level input.
`timescale 1ns/100ps
module sync_two_flop (
  input  wire clk_in,
  input  wire nrst_in,
  input  wire d_in,
  output wire q_out
);

  reg meta_reg;
  reg sync_reg;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;

endmodule
